//--- usf_pkg.sv
// Package for the serial-port flag word block: offsets, fields, resets.
// Assumes an AXI4-Lite slave with 32-bit data and word-aligned registers.
package usf_pkg;

  // ---------------------------------------------------------------------
  // Register offsets (byte addresses).
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFS_CTRL = 8'h48;

  // ---------------------------------------------------------------------
  // Flag word field positions.
  // ---------------------------------------------------------------------
  localparam int BIT_CTS = 0;
  localparam int BIT_BUSY = 3;
  localparam int BIT_RX_EMPTY = 4;
  localparam int BIT_TX_FULL = 5;
  localparam int BIT_RX_FULL = 6;
  localparam int BIT_TX_EMPTY = 7;
  localparam int BIT_CTS_CHANGE = 9;
  localparam int BIT_RSV_LO = 10;
  localparam int BIT_RSV_HI = 12;
  localparam int BIT_REMOTE_STOP = 13;

  // ---------------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------------
  localparam logic [2:0] RST_RSV_FIELD = 3'h7;
  localparam logic RST_CTS_CHANGE = 1'b1;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;
  localparam logic [1:0] RST_CTRL = 2'h0;

  // ---------------------------------------------------------------------
  // Interrupt status bit positions and control bit positions.
  // ---------------------------------------------------------------------
  localparam int IRQ_CTS_CHANGE = 0;
  localparam int IRQ_REMOTE_STOP = 1;
  localparam int IRQ_REMOTE_GO = 2;
  localparam int IRQ_TX_IDLE = 3;
  localparam int IRQ_W = 4;
  localparam int CTRL_FIFO_EN = 0;
  localparam int CTRL_RX_FIFO_EN = 1;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : usf_pkg

//--- usf_cts_sync.sv
// Two-stage synchroniser and change detector for the clear-to-send line.
// Assumes a single clock; the input may toggle at any time.
`timescale 1ns/1ps

module usf_cts_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cts_in,
  output logic cts_level,
  output logic cts_toggle
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // The first stage feeds only the second; edges are detected later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= cts_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign cts_level = sync_ff;
  assign cts_toggle = sync_ff ^ last_ff; // One-cycle pulse on any change.

endmodule // usf_cts_sync

//--- usf_flow_ctl.sv
// Software flow-control tracker: remembers whether Xoff was last sent.
// Assumes the transmitter pulses xoff_sent or xon_sent once per character.
`timescale 1ns/1ps

module usf_flow_ctl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic xoff_sent,
  input wire logic xon_sent,
  output logic remote_stopped,
  output logic stop_pulse,
  output logic go_pulse
);

  logic stopped_ff;

  // Xoff sets the state and wins over a same-cycle Xon; Xon clears it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stopped_ff <= 1'b0;
    end else if (xoff_sent) begin
      stopped_ff <= 1'b1;
    end else if (xon_sent) begin
      stopped_ff <= 1'b0;
    end
  end

  assign remote_stopped = stopped_ff;
  assign stop_pulse = xoff_sent & ~stopped_ff;
  assign go_pulse = xon_sent & ~xoff_sent & stopped_ff;

endmodule // usf_flow_ctl

//--- usf_flags.sv
// Flag word of an asynchronous serial port, with an AXI4-Lite slave.
// Assumes FIFO fill levels and transmitter activity come from the port.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps

module usf_flags #(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16,
  parameter int CNT_W = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address channel.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port-side state.
  input wire logic [CNT_W-1:0] tx_fifo_count,
  input wire logic [CNT_W-1:0] rx_fifo_count,
  input wire logic tx_hold_full,
  input wire logic rx_hold_full,
  input wire logic tx_shift_active,
  input wire logic tx_enable,
  input wire logic cts_in,
  input wire logic xoff_sent,
  input wire logic xon_sent,
  // Mode and interrupt outputs towards the port.
  output logic fifo_enable,
  output logic rx_fifo_enable,
  output logic irq
);

  // ---------------------------------------------------------------------
  // Local signals.
  // ---------------------------------------------------------------------
  logic cts_level;
  logic cts_toggle;
  logic remote_stopped;
  logic stop_pulse;
  logic go_pulse;
  logic [31:0] flags_ff;
  logic [31:0] nxt_flags;
  logic cts_change_ff;
  logic [usf_pkg::IRQ_W-1:0] irq_status_ff;
  logic [usf_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [usf_pkg::IRQ_W-1:0] irq_events;
  logic fifo_en_ff;
  logic rx_fifo_en_ff;
  logic busy_prev_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic irq_ff;
  logic busy;
  logic rd_take;
  logic wr_fire;
  logic rd_flags;
  logic rd_status;

  // ---------------------------------------------------------------------
  // Submodules.
  // ---------------------------------------------------------------------
  usf_cts_sync u_cts (
    .aclk(aclk),
    .aresetn(aresetn),
    .cts_in(cts_in),
    .cts_level(cts_level),
    .cts_toggle(cts_toggle)
  );

  usf_flow_ctl u_flow (
    .aclk(aclk),
    .aresetn(aresetn),
    .xoff_sent(xoff_sent),
    .xon_sent(xon_sent),
    .remote_stopped(remote_stopped),
    .stop_pulse(stop_pulse),
    .go_pulse(go_pulse)
  );

  // Word address decode, used by both the read and write paths.
  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] ofs);
    addr_is = (a[7:2] == ofs[7:2]);
  endfunction

  // ---------------------------------------------------------------------
  // Flag computation.
  // ---------------------------------------------------------------------

  // A paused character keeps busy low until transmit is enabled again,
  // while a non-empty transmit FIFO forces busy regardless of enable.
  assign busy = (tx_shift_active & tx_enable)
              | (tx_fifo_count != '0);

  // The flag word is registered so reads see one coherent snapshot.
  always_comb begin
    nxt_flags = 32'h0000_0000;
    nxt_flags[usf_pkg::BIT_CTS] = cts_level;
    nxt_flags[usf_pkg::BIT_BUSY] = busy;
    if (fifo_en_ff) begin
      nxt_flags[usf_pkg::BIT_TX_FULL] =
        (tx_fifo_count == CNT_W'(TX_DEPTH));
      nxt_flags[usf_pkg::BIT_TX_EMPTY] = (tx_fifo_count == '0);
    end else begin
      nxt_flags[usf_pkg::BIT_TX_FULL] = tx_hold_full;
      nxt_flags[usf_pkg::BIT_TX_EMPTY] = ~tx_hold_full;
    end
    // The receive side needs both its own enable and the FIFO enable; either low means character mode.
    if (fifo_en_ff && rx_fifo_en_ff) begin
      nxt_flags[usf_pkg::BIT_RX_EMPTY] = (rx_fifo_count == '0);
      nxt_flags[usf_pkg::BIT_RX_FULL] =
        (rx_fifo_count == CNT_W'(RX_DEPTH));
    end else begin
      nxt_flags[usf_pkg::BIT_RX_EMPTY] = ~rx_hold_full;
      nxt_flags[usf_pkg::BIT_RX_FULL] = rx_hold_full;
    end
    nxt_flags[usf_pkg::BIT_CTS_CHANGE] = cts_change_ff;
    nxt_flags[usf_pkg::BIT_RSV_HI:usf_pkg::BIT_RSV_LO] =
      usf_pkg::RST_RSV_FIELD;
    nxt_flags[usf_pkg::BIT_REMOTE_STOP] = remote_stopped;
  end

  // Snapshot register; reset shows both empty flags high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= 32'h0000_0000;
      flags_ff[usf_pkg::BIT_RX_EMPTY] <= 1'b1;
      flags_ff[usf_pkg::BIT_TX_EMPTY] <= 1'b1;
      flags_ff[usf_pkg::BIT_CTS_CHANGE] <= usf_pkg::RST_CTS_CHANGE;
      flags_ff[usf_pkg::BIT_RSV_HI:usf_pkg::BIT_RSV_LO] <=
        usf_pkg::RST_RSV_FIELD;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Change flag: a new toggle wins over the clear made by a read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cts_change_ff <= usf_pkg::RST_CTS_CHANGE;
    end else if (cts_toggle) begin
      cts_change_ff <= 1'b1;
    end else if (rd_take && rd_flags) begin
      cts_change_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Interrupts.
  // ---------------------------------------------------------------------

  // Transmit-idle event marks the falling edge of busy.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_prev_ff <= 1'b0;
    end else begin
      busy_prev_ff <= busy;
    end
  end

  always_comb begin
    irq_events = '0;
    irq_events[usf_pkg::IRQ_CTS_CHANGE] = cts_toggle;
    irq_events[usf_pkg::IRQ_REMOTE_STOP] = stop_pulse;
    irq_events[usf_pkg::IRQ_REMOTE_GO] = go_pulse;
    irq_events[usf_pkg::IRQ_TX_IDLE] = busy_prev_ff & ~busy;
  end

  // Sticky status; a read clears it but a same-cycle event survives.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_ff <= '0;
    end else if (rd_take && rd_status) begin
      irq_status_ff <= irq_events;
    end else begin
      irq_status_ff <= irq_status_ff | irq_events;
    end
  end

  // Level interrupt, registered to keep the output glitch free.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // ---------------------------------------------------------------------
  // AXI4-Lite write path.
  // ---------------------------------------------------------------------

  // Address and data are latched independently, in either order.
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
    end else if (s_axi_awvalid && !aw_held_ff) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid && !w_held_ff) begin
      w_held_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  // Writable control registers; the flag word itself ignores writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_ff <= usf_pkg::RST_IRQ_MASK;
      fifo_en_ff <= usf_pkg::RST_CTRL[usf_pkg::CTRL_FIFO_EN];
      rx_fifo_en_ff <= usf_pkg::RST_CTRL[usf_pkg::CTRL_RX_FIFO_EN];
    end else if (wr_fire && w_strb_ff[0]) begin
      if (addr_is(aw_addr_ff, usf_pkg::OFS_IRQ_MASK)) begin
        irq_mask_ff <= w_data_ff[usf_pkg::IRQ_W-1:0];
      end
      if (addr_is(aw_addr_ff, usf_pkg::OFS_CTRL)) begin
        fifo_en_ff <= w_data_ff[usf_pkg::CTRL_FIFO_EN];
        rx_fifo_en_ff <= w_data_ff[usf_pkg::CTRL_RX_FIFO_EN];
      end
    end
  end

  // Response: unmapped addresses get SLVERR; the flag word is OKAY.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= usf_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      if (addr_is(aw_addr_ff, usf_pkg::OFS_IRQ_MASK) ||
          addr_is(aw_addr_ff, usf_pkg::OFS_CTRL) ||
          addr_is(aw_addr_ff, usf_pkg::OFS_IRQ_STATUS) ||
          addr_is(aw_addr_ff, usf_pkg::OFS_FLAGS)) begin
        bresp_ff <= usf_pkg::RESP_OKAY;
      end else begin
        bresp_ff <= usf_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // AXI4-Lite read path.
  // ---------------------------------------------------------------------

  // One read at a time: arready is offered only while no data waits.
  assign rd_take = s_axi_arvalid && arready_ff;
  assign rd_flags = addr_is(s_axi_araddr, usf_pkg::OFS_FLAGS);
  assign rd_status = addr_is(s_axi_araddr, usf_pkg::OFS_IRQ_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
    end else begin
      arready_ff <= !rvalid_ff && !rd_take;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= usf_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= usf_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      if (rd_flags) begin
        rdata_ff <= flags_ff;
        // Live change bit, so the read returns exactly what it clears.
        rdata_ff[usf_pkg::BIT_CTS_CHANGE] <= cts_change_ff;
      end else if (rd_status) begin
        rdata_ff[usf_pkg::IRQ_W-1:0] <= irq_status_ff;
      end else if (addr_is(s_axi_araddr, usf_pkg::OFS_IRQ_MASK)) begin
        rdata_ff[usf_pkg::IRQ_W-1:0] <= irq_mask_ff;
      end else if (addr_is(s_axi_araddr, usf_pkg::OFS_CTRL)) begin
        rdata_ff[usf_pkg::CTRL_FIFO_EN] <= fifo_en_ff;
        rdata_ff[usf_pkg::CTRL_RX_FIFO_EN] <= rx_fifo_en_ff;
      end else begin
        rresp_ff <= usf_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs, all from flip-flops; awready and wready through an inverter.
  // ---------------------------------------------------------------------
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready = !w_held_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign fifo_enable = fifo_en_ff;
  assign rx_fifo_enable = rx_fifo_en_ff;
  assign irq = irq_ff;

endmodule // usf_flags

//--- usf_flags_checker.sv
// Checker for the flag word block: read timing and flag values on reads.
// Assumes it is bound to usf_flags and sees only that module's ports.
`timescale 1ns/1ps

module usf_flags_checker #(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16,
  parameter int CNT_W = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CNT_W-1:0] tx_fifo_count,
  input wire logic [CNT_W-1:0] rx_fifo_count,
  input wire logic tx_hold_full,
  input wire logic rx_hold_full,
  input wire logic tx_shift_active,
  input wire logic tx_enable,
  input wire logic cts_in,
  input wire logic fifo_enable,
  input wire logic rx_fifo_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------
  logic [2*CNT_W+6:0] vec;
  logic [2*CNT_W+6:0] vec_ff;
  logic [2:0] still_ff;
  logic is_fl_ff;
  logic fl;
  logic rxq;
  logic txq;

  // Flag values are judged only once the port state has been still for
  // seven edges, because the snapshot and the line synchroniser lag.
  assign vec = {tx_fifo_count, rx_fifo_count, tx_hold_full, rx_hold_full,
    tx_shift_active, tx_enable, cts_in, fifo_enable, rx_fifo_enable};
  always_ff @(posedge aclk) begin
    vec_ff <= vec;
    if (!aresetn || vec != vec_ff) begin
      still_ff <= 3'h0;
    end else if (still_ff != 3'h7) begin
      still_ff <= still_ff + 3'h1;
    end
  end

  // Remembers whether the read under way addresses the flag word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      is_fl_ff <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      is_fl_ff <= s_axi_araddr[7:2] == usf_pkg::OFS_FLAGS[7:2];
    end
  end

  // Flag word answer with settled inputs, and the two FIFO modes.
  assign fl = s_axi_rvalid && is_fl_ff && still_ff == 3'h7;
  assign txq = fifo_enable;
  assign rxq = fifo_enable && rx_fifo_enable;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  a_busy_flag: assert property (fl |-> s_axi_rdata[3] ==
    (tx_shift_active && tx_enable || tx_fifo_count != 0))
    else $error("busy flag wrong");
  a_rx_empty: assert property (fl |-> s_axi_rdata[4] ==
    (rxq ? rx_fifo_count == 0 : !rx_hold_full)) else $error("rx empty");
  a_tx_full: assert property (fl |-> s_axi_rdata[5] ==
    (txq ? tx_fifo_count == TX_DEPTH : tx_hold_full)) else $error("tx full");
  a_rx_full: assert property (fl |-> s_axi_rdata[6] ==
    (rxq ? rx_fifo_count == RX_DEPTH : rx_hold_full)) else $error("rx full");
  a_tx_empty: assert property (fl |-> s_axi_rdata[7] ==
    (txq ? tx_fifo_count == 0 : !tx_hold_full)) else $error("tx empty");
  a_cts_level: assert property (fl |-> s_axi_rdata[0] == cts_in)
    else $error("cts level wrong");
  a_fixed_fields: assert property (s_axi_rvalid && is_fl_ff
    |-> s_axi_rdata[12:10] == 3'h7 && s_axi_rdata[2:1] == 2'h0
    && s_axi_rdata[31:14] == 18'h0 && !s_axi_rdata[8])
    else $error("fixed fields wrong");

  // Main scenarios reached.
  c_busy_read: cover property (fl && s_axi_rdata[3]);
  c_fifo_mode: cover property (fl && rxq);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule // usf_flags_checker

bind usf_flags usf_flags_checker #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH),
  .CNT_W(CNT_W)) chk (.*);

//--- usf_line_model.sv
// Line-side partner: remote handshake line, flow characters and shifter.
// Assumes the bench calls its tasks; every change follows a rising edge.
`timescale 1ns/1ps

module usf_line_model (
  input wire logic aclk,
  output logic cts_in,
  output logic xoff_sent,
  output logic xon_sent,
  output logic tx_shift_active
);
  // Quiet line at time zero: remote not ready, nothing in the shifter.
  initial begin
    cts_in = 1'b0;
    xoff_sent = 1'b0;
    xon_sent = 1'b0;
    tx_shift_active = 1'b0;
  end

  // Level changes of the handshake line and of the shift register.
  task automatic set_line(input logic cts, input logic shift);
    @(posedge aclk);
    cts_in <= cts;
    tx_shift_active <= shift;
  endtask

  // One flow character leaves the port; each is a single-cycle pulse.
  task automatic send(input logic stop);
    @(posedge aclk);
    xoff_sent <= stop;
    xon_sent <= !stop;
    @(posedge aclk);
    xoff_sent <= 1'b0;
    xon_sent <= 1'b0;
  endtask
endmodule // usf_line_model

//--- usf_flags_tb.sv
// Self-checking bench for the flag word block over AXI4-Lite.
// Assumes usf_flags, its checker and the line model are compiled first.
`timescale 1ns/1ps

module usf_flags_tb;
  localparam int DEPTH = 16;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, ctrl_v;
  logic [4:0] tx_fifo_count, rx_fifo_count;
  logic tx_hold_full, rx_hold_full, tx_shift_active, tx_enable, cts_in;
  logic xoff_sent, xon_sent, fifo_enable, rx_fifo_enable, cts_v, shift_v;
  logic [4:0] cnt [4] = '{5'h00, 5'h01, 5'h0f, 5'h10};
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;

  usf_flags #(.TX_DEPTH(DEPTH), .RX_DEPTH(DEPTH), .CNT_W(5)) dut (.*);
  usf_line_model lm (.aclk(aclk), .cts_in(cts_in), .xoff_sent(xoff_sent),
    .xon_sent(xon_sent), .tx_shift_active(tx_shift_active));

  // ---------------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ---------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // The whole run needs well under two thousand cycles.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Address and data are offered together and each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    @(posedge aclk);
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dv,
                    output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    dv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Flag word expected from the port state that the bench has set up.
  function automatic logic [31:0] exp_fl(input logic chg, input logic stp);
    logic [31:0] e;
    logic fq, rq;
    fq = ctrl_v[0];
    rq = ctrl_v[0] && ctrl_v[1];
    e = 32'h0000_1c00;
    e[0] = cts_v;
    e[3] = (shift_v && tx_enable) || tx_fifo_count != 5'h00;
    e[4] = rq ? rx_fifo_count == 5'h00 : !rx_hold_full;
    e[5] = fq ? tx_fifo_count == DEPTH : tx_hold_full;
    e[6] = rq ? rx_fifo_count == DEPTH : rx_hold_full;
    e[7] = fq ? tx_fifo_count == 5'h00 : !tx_hold_full;
    e[9] = chg;
    e[13] = stp;
    return e;
  endfunction

  // ---------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, tx_hold_full, rx_hold_full} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {tx_fifo_count, rx_fifo_count, tx_enable} = 11'h0;
    s_axi_wstrb = 4'hf;
    {ctrl_v, cts_v, shift_v} = 4'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(usf_pkg::OFS_FLAGS, d, r);
    chk(d, exp_fl(1'b1, 1'b0));
    rd(usf_pkg::OFS_FLAGS, d, r);
    chk(d, exp_fl(1'b0, 1'b0));
    wr(usf_pkg::OFS_FLAGS, 32'hffff_ffff, r);
    chk({30'h0, r}, {30'h0, usf_pkg::RESP_OKAY});
    rd(usf_pkg::OFS_FLAGS, d, r);
    chk(d, exp_fl(1'b0, 1'b0));
    rd(usf_pkg::OFS_IRQ_MASK, d, r);
    chk(d, {28'h0, usf_pkg::RST_IRQ_MASK});
    rd(8'h30, d, r);
    chk({30'h0, r}, {30'h0, usf_pkg::RESP_SLVERR});
    wr(8'h30, 32'h0000_0003, r);
    chk({30'h0, r}, {30'h0, usf_pkg::RESP_SLVERR});
    $display("test reset_and_access done");
    cts_v = 1'b1;
    lm.set_line(cts_v, shift_v);
    repeat (10) @(posedge aclk);
    rd(usf_pkg::OFS_FLAGS, d, r);
    chk(d, exp_fl(1'b1, 1'b0));
    rd(usf_pkg::OFS_FLAGS, d, r);
    chk(d, exp_fl(1'b0, 1'b0));
    $display("test cts_change done");
    // Walks busy, fill flags and both modes through a table of states.
    for (int i = 0; i < 32; i++) begin
      ctrl_v = i[3:2];
      wr(usf_pkg::OFS_CTRL, {30'h0, ctrl_v}, r);
      chk({30'h0, rx_fifo_enable, fifo_enable}, {30'h0, ctrl_v});
      @(posedge aclk);
      tx_fifo_count <= cnt[i[4:3]];
      rx_fifo_count <= cnt[i[1:0] ^ i[4:3]];
      tx_hold_full <= i[2];
      rx_hold_full <= i[3] ^ i[0];
      tx_enable <= i[1];
      shift_v = i[0];
      lm.set_line(cts_v, shift_v);
      repeat (10) @(posedge aclk);
      rd(usf_pkg::OFS_FLAGS, d, r);
      chk(d, exp_fl(1'b0, 1'b0));
    end
    $display("test flag_table done");
    rd(usf_pkg::OFS_IRQ_STATUS, d, r);
    wr(usf_pkg::OFS_IRQ_MASK, 32'h0000_0002, r);
    lm.send(1'b1);
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(usf_pkg::OFS_FLAGS, d, r);
    chk(d, exp_fl(1'b0, 1'b1));
    rd(usf_pkg::OFS_IRQ_STATUS, d, r);
    chk(d, 32'h0000_0002);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    lm.send(1'b0);
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(usf_pkg::OFS_FLAGS, d, r);
    chk(d, exp_fl(1'b0, 1'b0));
    rd(usf_pkg::OFS_IRQ_STATUS, d, r);
    chk(d, 32'h0000_0004);
    $display("test flow_control done");
    // Line change and transmitter going idle, both unmasked.
    wr(usf_pkg::OFS_IRQ_MASK, 32'h0000_0009, r);
    tx_fifo_count <= 5'h00;
    cts_v = 1'b0;
    shift_v = 1'b0;
    lm.set_line(cts_v, shift_v);
    repeat (10) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(usf_pkg::OFS_IRQ_STATUS, d, r);
    chk(d, 32'h0000_0009);
    rd(usf_pkg::OFS_FLAGS, d, r);
    chk(d, exp_fl(1'b1, 1'b0));
    $display("test irq_events done");
    results();
  end
endmodule // usf_flags_tb
